// ===== rtl/pbmc_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the mode control bank
// Assumes: 100 MHz register clock
// Notes:   included by the control module, the checker and the bench
`ifndef PBMC_CONSTS_SVH
`define PBMC_CONSTS_SVH

// register offsets
`define PBMC_ADDR_CONTROL     5'h00
`define PBMC_ADDR_STATUS      5'h01

// control field positions
`define PBMC_BIT_RESET        15
`define PBMC_BIT_LOOPBACK     14
`define PBMC_BIT_SPEED        13
`define PBMC_BIT_ANEG         12
`define PBMC_BIT_POWER_DOWN   11
`define PBMC_BIT_ISOLATE      10
`define PBMC_BIT_DUPLEX       8

// status field positions
`define PBMC_STAT_LINK_OK     0
`define PBMC_STAT_FAULT       1
`define PBMC_STAT_RX_ERROR    2
`define PBMC_STAT_BUSY        3
`define PBMC_STAT_CAPABLE     4
`define PBMC_STAT_CELLS       5

// reset values
`define PBMC_FIXED_CAPABLE    1'b1
`define PBMC_ZERO16           16'h0000

// timing
`define PBMC_CLK_MHZ          100
`define PBMC_SOFT_RESET_CYC   16
`define PBMC_DEAD_TIME_US     500
`define PBMC_DEAD_TIME_CYC    (`PBMC_DEAD_TIME_US * `PBMC_CLK_MHZ)

`endif

// ===== rtl/pbmc_pkg.sv
// Purpose: types shared by the mode control bank
// Assumes: constants come from pbmc_consts.svh
// Notes:   states are one-hot
`default_nettype none

package pbmc_pkg;

  // control sequencer states
  typedef enum logic [2:0] {
    PBMC_ST_INIT  = 3'b001,
    PBMC_ST_RUN   = 3'b010,
    PBMC_ST_SWRST = 3'b100
  } pbmc_state_type;

  // access behaviour of one status cell
  typedef enum logic [2:0] {
    PBMC_CELL_SC    = 3'h0,
    PBMC_CELL_COR   = 3'h1,
    PBMC_CELL_LL    = 3'h2,
    PBMC_CELL_LH    = 3'h3,
    PBMC_CELL_FIXED = 3'h4
  } pbmc_cell_type;

  // live conditions from the surrounding PHY logic
  typedef struct packed {
    logic busy;
    logic rx_error;
    logic fault;
    logic link_ok;
  } pbmc_status_in_type;

  // negotiated result used while auto-negotiation runs
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
  } pbmc_aneg_type;

endpackage : pbmc_pkg

`default_nettype wire

// ===== rtl/pbmc_status_bit.sv
// Purpose: one status bit with a selectable access behaviour
// Assumes: live and clear_req are on CLK
// Notes:   a read reloads from the live level, so an event in the read cycle is kept
`default_nettype none

module pbmc_status_bit #(
  parameter pbmc_pkg::pbmc_cell_type MODE      = pbmc_pkg::PBMC_CELL_SC,
  parameter logic                    FIXED_VAL = 1'b0,
  parameter logic                    RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST_N,
  // condition and read side effect
  input  wire logic live,
  input  wire logic clear_req,
  // bit value
  output var  logic value
);
  import pbmc_pkg::*;

  logic next_value;

  // next value per access behaviour
  always_comb begin
    next_value = value;
    case (MODE)
      PBMC_CELL_SC:  next_value = live;                                  // [RULE1]
      PBMC_CELL_COR: next_value = clear_req ? live : (value | live);     // [RULE2]
      PBMC_CELL_LL:  next_value = clear_req ? live : (value & live);     // [RULE3]
      PBMC_CELL_LH:  next_value = clear_req ? live : (value | live);     // [RULE4]
      default:       next_value = FIXED_VAL;                             // [RULE5]
    endcase
  end

  // state bit
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      value <= (MODE == PBMC_CELL_FIXED) ? FIXED_VAL : RESET_VAL;
    end else begin
      value <= next_value;
    end
  end

endmodule : pbmc_status_bit

`default_nettype wire

// ===== rtl/pbmc_control.sv
// Function
// (RULE1) self-clearing bit sets when its event starts, clears itself when it ends
// (RULE2) clear-on-read bit ignores writes and clears when read
// (RULE3) latched-low bit falls on its event and stays low until read
// (RULE4) latched-high bit rises on its event and stays high until read
// (RULE5) fixed bit always reads its default, never changes
// (RULE6) writing one to bit 15 starts soft reset, reads one, self-clears, re-straps
// (RULE7) bit 14 loops transmit data back to receive; resets to zero
// (RULE8) enabling loopback blanks valid receive data for a 500 us dead time
// (RULE9) bit 13 picks 100 or 10 Mb/s when negotiation is off; strap default
// (RULE10) bit 12 strap default, forced to zero whenever fiber mode is on
// (RULE11) negotiation on ignores bits 13 and 8; off, they set speed and duplex
// (RULE12) bit 11 powers down the PHY except registers; resets to zero
// (RULE13) power down is bit 11 OR the low pin; the pin sets the bit
// (RULE14) bit 10 isolates the port from MII, management stays alive; zero default
// (RULE15) bit 8 picks full or half duplex when negotiation is off; strap default
// (RULE16) during soft reset other bits hold strap values and ignore writes
//
// Purpose: basic mode control register and status bank of a 10/100 transceiver
// Assumes: straps, fiber select and power-down pin are asynchronous pins
// Notes:   hardware reset runs the same strap capture as a soft reset
//
// Local design decision: the strobed register port.
`default_nettype none
`include "pbmc_consts.svh"

module pbmc_control #(
  parameter int SOFT_RESET_CYCLES = `PBMC_SOFT_RESET_CYC,
  parameter int DEAD_TIME_CYCLES  = `PBMC_DEAD_TIME_CYC
) (
  // clock and reset
  input  wire logic                         CLK,
  input  wire logic                         RST_N,
  // register port
  input  wire logic [4:0]                   REG_ADDR,
  input  wire logic [15:0]                  REG_WDATA,
  input  wire logic                         REG_WR,
  input  wire logic                         REG_RD,
  output var  logic [15:0]                  REG_RDATA,
  // strap and pin inputs
  input  wire logic                         STRAP_SPEED_100,
  input  wire logic                         STRAP_ANEG_ENABLE,
  input  wire logic                         STRAP_FULL_DUPLEX,
  input  wire logic                         FIBER_MODE_ENABLE,
  input  wire logic                         POWER_DOWN_INPUT_PIN_N,
  // on-chip inputs
  input  wire pbmc_pkg::pbmc_aneg_type      ANEG_RESULT,
  input  wire pbmc_pkg::pbmc_status_in_type STATUS_LIVE,
  // mode outputs
  output var  logic                         SOFT_RESET,
  output var  logic                         LOOPBACK,
  output var  logic                         RX_DEAD_TIME,
  output var  logic                         SPEED_100,
  output var  logic                         FULL_DUPLEX,
  output var  logic                         ANEG_ENABLE,
  output var  logic                         POWER_DOWN,
  output var  logic                         ISOLATE
);
  import pbmc_pkg::*;

  localparam logic [15:0] RST_LAST  = 16'(SOFT_RESET_CYCLES - 1);
  localparam logic [15:0] DEAD_LAST = 16'(DEAD_TIME_CYCLES - 1);

  // pin synchronisers, first stage read only by the second
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_meta <= 5'h1f;
      pin_sync <= 5'h1f;
    end else begin
      pin_meta <= {POWER_DOWN_INPUT_PIN_N, FIBER_MODE_ENABLE, STRAP_FULL_DUPLEX,
                   STRAP_ANEG_ENABLE, STRAP_SPEED_100};
      pin_sync <= pin_meta;
    end
  end

  // named synchronised levels
  wire s_speed  = pin_sync[0];
  wire s_aneg   = pin_sync[1];
  wire s_duplex = pin_sync[2];
  wire s_fiber  = pin_sync[3];
  wire s_pd_pin = ~pin_sync[4];

  // address decode
  wire sel_ctrl = (REG_ADDR == `PBMC_ADDR_CONTROL);
  wire sel_stat = (REG_ADDR == `PBMC_ADDR_STATUS);
  wire wr_ctrl  = REG_WR && sel_ctrl;
  wire rd_stat  = REG_RD && sel_stat;

  // sequencer
  pbmc_state_type state;
  pbmc_state_type next_state;
  logic [15:0]    rst_cnt;
  logic [15:0]    next_rst_cnt;

  // stored control bits
  logic bit_loop;
  logic bit_speed;
  logic bit_aneg;
  logic bit_pd;
  logic bit_iso;
  logic bit_duplex;

  wire running  = (state == PBMC_ST_RUN);
  wire seq_done = (state != PBMC_ST_RUN) && (rst_cnt == RST_LAST);
  wire sw_start = running && wr_ctrl && REG_WDATA[`PBMC_BIT_RESET];            // [RULE6]
  wire accept   = running && wr_ctrl && !REG_WDATA[`PBMC_BIT_RESET];           // [RULE16]

  // sequencer transitions; straps are re-captured in every cycle of either reset
  always_comb begin
    next_state   = state;
    next_rst_cnt = rst_cnt;
    case (state)
      PBMC_ST_INIT, PBMC_ST_SWRST: begin
        next_rst_cnt = rst_cnt + 16'h0001;
        if (seq_done) begin
          next_state   = PBMC_ST_RUN;                                          // [RULE6]
          next_rst_cnt = 16'h0000;
        end
      end
      PBMC_ST_RUN: begin
        if (sw_start) begin
          next_state   = PBMC_ST_SWRST;                                        // [RULE6]
          next_rst_cnt = 16'h0000;
        end
      end
      default: begin
        next_state   = PBMC_ST_INIT;
        next_rst_cnt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state   <= PBMC_ST_INIT;
      rst_cnt <= 16'h0000;
    end else begin
      state   <= next_state;
      rst_cnt <= next_rst_cnt;
    end
  end

  // next values of the stored bits
  logic next_loop;
  logic next_speed;
  logic next_aneg;
  logic next_pd;
  logic next_iso;
  logic next_duplex;

  always_comb begin
    next_loop   = bit_loop;
    next_speed  = bit_speed;
    next_aneg   = bit_aneg;
    next_pd     = bit_pd;
    next_iso    = bit_iso;
    next_duplex = bit_duplex;
    if (!running) begin
      // held at defaults while reset runs, re-strapped each cycle
      next_loop   = 1'b0;                                                      // [RULE16]
      next_speed  = s_speed;                                                   // [RULE6] [RULE9]
      next_aneg   = s_aneg;                                                    // [RULE6]
      next_pd     = 1'b0;
      next_iso    = 1'b0;
      next_duplex = s_duplex;                                                  // [RULE15]
    end else if (accept) begin
      next_loop   = REG_WDATA[`PBMC_BIT_LOOPBACK];                             // [RULE7]
      next_speed  = REG_WDATA[`PBMC_BIT_SPEED];                                // [RULE9]
      next_aneg   = REG_WDATA[`PBMC_BIT_ANEG];
      next_pd     = REG_WDATA[`PBMC_BIT_POWER_DOWN];                           // [RULE12]
      next_iso    = REG_WDATA[`PBMC_BIT_ISOLATE];                              // [RULE14]
      next_duplex = REG_WDATA[`PBMC_BIT_DUPLEX];                               // [RULE15]
    end
    // fiber overrides any strap or write
    if (s_fiber) begin
      next_aneg = 1'b0;                                                        // [RULE10]
    end
    // the pin sets the bit and beats a write clearing it
    if (s_pd_pin) begin
      next_pd = 1'b1;                                                          // [RULE13]
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bit_loop   <= 1'b0;
      bit_speed  <= 1'b0;
      bit_aneg   <= 1'b0;
      bit_pd     <= 1'b0;
      bit_iso    <= 1'b0;
      bit_duplex <= 1'b0;
    end else begin
      bit_loop   <= next_loop;
      bit_speed  <= next_speed;
      bit_aneg   <= next_aneg;
      bit_pd     <= next_pd;
      bit_iso    <= next_iso;
      bit_duplex <= next_duplex;
    end
  end

  // loopback dead time: restarts on every rising edge of the loopback bit
  logic        dead_active;
  logic [15:0] dead_cnt;
  wire         loop_rise = next_loop && !bit_loop;
  wire         dead_end  = dead_active && (dead_cnt == DEAD_LAST);
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dead_active <= 1'b0;
      dead_cnt    <= 16'h0000;
    end else if (loop_rise) begin
      dead_active <= 1'b1;                                                     // [RULE8]
      dead_cnt    <= 16'h0000;
    end else if (dead_active) begin
      dead_active <= !dead_end;                                                // [RULE8]
      dead_cnt    <= dead_cnt + 16'h0001;
    end
  end

  // effective modes; negotiation result wins while negotiation is on
  wire eff_speed  = next_aneg ? ANEG_RESULT.speed_100   : next_speed;          // [RULE11]
  wire eff_duplex = next_aneg ? ANEG_RESULT.full_duplex : next_duplex;         // [RULE11]
  wire eff_pd     = next_pd | s_pd_pin;                                        // [RULE13]

  // registered mode outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SOFT_RESET   <= 1'b1;
      LOOPBACK     <= 1'b0;
      RX_DEAD_TIME <= 1'b0;
      SPEED_100    <= 1'b0;
      FULL_DUPLEX  <= 1'b0;
      ANEG_ENABLE  <= 1'b0;
      POWER_DOWN   <= 1'b0;
      ISOLATE      <= 1'b0;
    end else begin
      SOFT_RESET   <= (next_state != PBMC_ST_RUN);
      LOOPBACK     <= next_loop;                                               // [RULE7]
      RX_DEAD_TIME <= loop_rise || (dead_active && !dead_end);                 // [RULE8]
      SPEED_100    <= eff_speed;                                               // [RULE9]
      FULL_DUPLEX  <= eff_duplex;                                              // [RULE15]
      ANEG_ENABLE  <= next_aneg;
      POWER_DOWN   <= eff_pd;                                                  // [RULE12]
      ISOLATE      <= next_iso;                                                // [RULE14]
    end
  end

  // status cells; a status read is the clear side effect
  localparam pbmc_cell_type CELL_MODE [`PBMC_STAT_CELLS] = '{
    PBMC_CELL_LL, PBMC_CELL_LH, PBMC_CELL_COR, PBMC_CELL_SC, PBMC_CELL_FIXED};
  localparam logic CELL_RESET [`PBMC_STAT_CELLS] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  wire [`PBMC_STAT_CELLS-1:0] cell_live = {1'b0, STATUS_LIVE.busy, STATUS_LIVE.rx_error,
                                           STATUS_LIVE.fault, STATUS_LIVE.link_ok};
  logic [`PBMC_STAT_CELLS-1:0] cell_value;

  genvar gi;
  generate
    for (gi = 0; gi < `PBMC_STAT_CELLS; gi++) begin : g_cell
      pbmc_status_bit #(
        .MODE      (CELL_MODE[gi]),
        .FIXED_VAL (`PBMC_FIXED_CAPABLE),
        .RESET_VAL (CELL_RESET[gi])
      ) u_cell (
        .CLK       (CLK),
        .RST_N     (RST_N),
        .live      (cell_live[gi]),
        .clear_req (rd_stat),                                                  // [RULE2]
        .value     (cell_value[gi])
      );
    end
  endgenerate

  // read words; unused and reserved bits read zero
  logic [15:0] ctrl_word;
  always_comb begin
    ctrl_word                        = `PBMC_ZERO16;
    ctrl_word[`PBMC_BIT_RESET]       = (state == PBMC_ST_SWRST);               // [RULE6]
    ctrl_word[`PBMC_BIT_LOOPBACK]    = bit_loop;
    ctrl_word[`PBMC_BIT_SPEED]       = bit_speed;
    ctrl_word[`PBMC_BIT_ANEG]        = bit_aneg;
    ctrl_word[`PBMC_BIT_POWER_DOWN]  = bit_pd;
    ctrl_word[`PBMC_BIT_ISOLATE]     = bit_iso;
    ctrl_word[`PBMC_BIT_DUPLEX]      = bit_duplex;
  end

  wire [15:0] stat_word = {11'h000, cell_value};
  wire [15:0] rd_word   = sel_ctrl ? ctrl_word : (sel_stat ? stat_word : `PBMC_ZERO16);

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= `PBMC_ZERO16;
    end else begin
      REG_RDATA <= REG_RD ? rd_word : `PBMC_ZERO16;
    end
  end

endmodule : pbmc_control

`default_nettype wire

// ===== verif/pbmc_checker_sva.sv
// Purpose: port-level checks of the mode control bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound into every pbmc_control instance
`default_nettype none
`include "pbmc_consts.svh"

module pbmc_checker (
  // clock and reset
  input wire logic                    CLK,
  input wire logic                    RST_N,
  // register port
  input wire logic [4:0]              REG_ADDR,
  input wire logic [15:0]             REG_WDATA,
  input wire logic                    REG_WR,
  input wire logic                    REG_RD,
  // pins and on-chip inputs
  input wire logic                    FIBER_MODE_ENABLE,
  input wire logic                    POWER_DOWN_INPUT_PIN_N,
  input wire pbmc_pkg::pbmc_aneg_type ANEG_RESULT,
  // mode outputs
  input wire logic                    SOFT_RESET,
  input wire logic                    LOOPBACK,
  input wire logic                    RX_DEAD_TIME,
  input wire logic                    SPEED_100,
  input wire logic                    FULL_DUPLEX,
  input wire logic                    ANEG_ENABLE,
  input wire logic                    POWER_DOWN,
  input wire logic                    ISOLATE
);
  import pbmc_pkg::*;

  // a control write that is accepted: running and not a soft reset request
  wire logic ctl_hit = REG_WR && (REG_ADDR == `PBMC_ADDR_CONTROL) && !SOFT_RESET;
  wire logic ctl_wr  = ctl_hit && !REG_WDATA[15];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_loop_follow: assert property (ctl_wr |=> LOOPBACK == $past(REG_WDATA[14]))
    else $error("loopback does not follow the written bit");
  chk_iso_follow: assert property (ctl_wr |=> ISOLATE == $past(REG_WDATA[10]))
    else $error("isolate does not follow the written bit");
  chk_pd_write: assert property (ctl_wr && REG_WDATA[11] |=> POWER_DOWN)
    else $error("power down bit did not power down");
  chk_sr_start: assert property (ctl_hit && REG_WDATA[15] |=> SOFT_RESET [*2])
    else $error("soft reset did not start");
  chk_sr_done: assert property ($rose(SOFT_RESET) |-> ##[1:40] !SOFT_RESET)
    else $error("soft reset never cleared itself");
  // first soft reset cycle still shows the old bits, hence the past term
  chk_sr_hold: assert property (SOFT_RESET && $past(SOFT_RESET)
    |-> !LOOPBACK && !ISOLATE)
    else $error("control bits not held during soft reset");
  chk_pd_pin: assert property (!POWER_DOWN_INPUT_PIN_N [*5] |-> POWER_DOWN)
    else $error("power down pin ignored");
  chk_fiber_aneg: assert property (FIBER_MODE_ENABLE [*5] |-> !ANEG_ENABLE)
    else $error("negotiation enabled in fiber mode");
  chk_dead_time: assert property ($rose(LOOPBACK) |-> RX_DEAD_TIME [*8])
    else $error("dead time too short after loopback");
  chk_aneg_used: assert property (ANEG_ENABLE && !SOFT_RESET && !$past(SOFT_RESET)
    |-> {SPEED_100, FULL_DUPLEX} == $past(ANEG_RESULT))
    else $error("negotiated speed or duplex not used");

  // main scenarios
  cover property ($rose(SOFT_RESET));
  cover property ($rose(RX_DEAD_TIME));
  cover property (REG_RD && REG_ADDR == `PBMC_ADDR_STATUS);
endmodule : pbmc_checker

bind pbmc_control pbmc_checker chk_u (
  .CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .FIBER_MODE_ENABLE(FIBER_MODE_ENABLE),
  .POWER_DOWN_INPUT_PIN_N(POWER_DOWN_INPUT_PIN_N), .ANEG_RESULT(ANEG_RESULT),
  .SOFT_RESET(SOFT_RESET), .LOOPBACK(LOOPBACK), .RX_DEAD_TIME(RX_DEAD_TIME),
  .SPEED_100(SPEED_100), .FULL_DUPLEX(FULL_DUPLEX), .ANEG_ENABLE(ANEG_ENABLE),
  .POWER_DOWN(POWER_DOWN), .ISOLATE(ISOLATE));

`default_nettype wire

// ===== verif/pbmc_host.sv
// Purpose: management host model issuing register cycles
// Assumes: read data stands only in the cycle after the read strobe
// Notes:   write data is scrambled after each write so stale data never helps
`default_nettype none

module pbmc_host (
  // clock
  input  wire logic        CLK,
  // register port
  output var  logic [4:0]  REG_ADDR,
  output var  logic [15:0] REG_WDATA,
  output var  logic        REG_WR,
  output var  logic        REG_RD,
  input  wire logic [15:0] REG_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  import pbmc_pkg::*;

  // idle bus at time zero
  initial begin
    REG_ADDR = 5'h1f;
    REG_WDATA = 16'h0000;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
  end

  // one-cycle write strobe
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CLK);
    REG_WR    <= 1'b0;
    REG_WDATA <= ~d;
  endtask : wr

  // one-cycle read strobe, data taken at the edge ending the answer cycle
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CLK);
    REG_RD   <= 1'b0;
    @(posedge CLK);
    d = REG_RDATA;
  endtask : rd
endmodule : pbmc_host

`default_nettype wire

// ===== verif/tb.sv
// Purpose: self-checking bench of the mode control bank
// Assumes: short soft reset and dead time counts
// Notes:   straps change only before a soft reset
`default_nettype none
`include "pbmc_consts.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pbmc_pkg::*;

  localparam logic [4:0] CTRL = `PBMC_ADDR_CONTROL;
  localparam logic [4:0] STAT = `PBMC_ADDR_STATUS;

  // stimulus and observation
  logic clk, rst_n = 1'b0, sp = 1'b1, an = 1'b0, dp = 1'b1, fib = 1'b0, pd_n = 1'b1;
  logic [4:0] addr;
  logic [15:0] wdata, rdata;
  logic wr, rd, sr, lb, dt, s100, fd, ae, pd, iso;
  pbmc_aneg_type ares = 2'b10;
  pbmc_status_in_type live = 4'b0001;
  int miscompares = 0;
  int comparisons = 0;
  wire logic [7:0] outs = {sr, lb, dt, s100, fd, ae, pd, iso};

  pbmc_control #(.SOFT_RESET_CYCLES(8), .DEAD_TIME_CYCLES(8)) dut_u (
    .CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .STRAP_SPEED_100(sp), .STRAP_ANEG_ENABLE(an),
    .STRAP_FULL_DUPLEX(dp), .FIBER_MODE_ENABLE(fib), .POWER_DOWN_INPUT_PIN_N(pd_n),
    .ANEG_RESULT(ares), .STATUS_LIVE(live), .SOFT_RESET(sr), .LOOPBACK(lb),
    .RX_DEAD_TIME(dt), .SPEED_100(s100), .FULL_DUPLEX(fd), .ANEG_ENABLE(ae),
    .POWER_DOWN(pd), .ISOLATE(iso));

  pbmc_host host_u (.CLK(clk), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rchk(input string what, input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host_u.rd(a, d);
    check(what, d, exp);
  endtask : rchk

  // outputs settle just after the edge that took the write
  task automatic ochk(input string what, input logic [7:0] exp);
    #1;
    check(what, {8'h00, outs}, {8'h00, exp});
  endtask : ochk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // bounded wait, a stuck sequencer must not hang the run
  task automatic wait_idle;
    for (int i = 0; i < 100 && sr !== 1'b0; i++) @(posedge clk);
    check("soft reset flag", {15'h0000, sr}, 16'h0000);
  endtask : wait_idle

  task automatic t_defaults;
    wait_idle();
    rchk("control after reset", CTRL, 16'h2100);
    ochk("outputs after reset", 8'h18);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_modes;
    host_u.wr(CTRL, 16'h4c00);
    ochk("loop pd iso outputs", 8'h63);
    rchk("control readback", CTRL, 16'h4c00);
    cyc(6);
    ochk("dead time over", 8'h43);
    host_u.wr(CTRL, 16'h2100);
    ochk("forced 100 full", 8'h18);
    host_u.wr(CTRL, 16'h0000);
    ochk("forced 10 half", 8'h00);
    host_u.wr(CTRL, 16'h3100);
    ochk("negotiated result", 8'h14);
    // a new result with opposite forced bits proves both forced bits are ignored
    cyc(1);
    ares <= 2'b01;
    host_u.wr(CTRL, 16'h3000);
    ochk("negotiated over forced", 8'h0c);
    $display("test modes done");
  endtask : t_modes

  task automatic t_pins;
    cyc(1);
    fib <= 1'b1;
    cyc(4);
    host_u.wr(CTRL, 16'h1000);
    rchk("aneg in fiber mode", CTRL, 16'h0000);
    fib <= 1'b0;
    pd_n <= 1'b0;
    cyc(4);
    host_u.wr(CTRL, 16'h0000);
    rchk("pin sets power down", CTRL, 16'h0800);
    pd_n <= 1'b1;
    cyc(4);
    host_u.wr(CTRL, 16'h0000);
    ochk("power up", 8'h00);
    $display("test pins done");
  endtask : t_pins

  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    live <= v;
    @(posedge clk);
    live <= 4'b0001;
  endtask : pulse

  task automatic t_status;
    rchk("status idle", STAT, 16'h0011);
    pulse(4'b0000);
    rchk("link latched", STAT, 16'h0010);
    rchk("link after read", STAT, 16'h0011);
    pulse(4'b0011);
    rchk("fault latched", STAT, 16'h0013);
    rchk("fault after read", STAT, 16'h0011);
    pulse(4'b0101);
    host_u.wr(STAT, 16'hffff);
    rchk("rx error held", STAT, 16'h0015);
    rchk("rx error cleared", STAT, 16'h0011);
    live <= 4'b1001;
    cyc(2);
    rchk("busy set", STAT, 16'h0019);
    live <= 4'b0001;
    cyc(2);
    rchk("busy cleared", STAT, 16'h0011);
    rchk("unmapped read", 5'h1f, 16'h0000);
    $display("test status done");
  endtask : t_status

  task automatic t_soft;
    host_u.wr(CTRL, 16'h4000);
    {sp, an, dp} <= 3'b010;
    cyc(4);
    host_u.wr(CTRL, 16'h8000);
    host_u.wr(CTRL, 16'h4400);
    rchk("reset in progress", CTRL, 16'h9000);
    wait_idle();
    rchk("restrapped", CTRL, 16'h1000);
    $display("test soft reset done");
  endtask : t_soft

  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // a run of under 150 cycles; far beyond that means a hang
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    t_modes();
    t_pins();
    t_status();
    t_soft();
    end_of_test();
  end
endmodule : tb

`default_nettype wire
